// >>> src/mdjb_pkg.sv
// Shared constants for the multidrop scan bridge and its backplane master
package mdjb_pkg;
    localparam int NPORT = 3;
    localparam int SLOT_W = 6;
    localparam int IR_W = 8;
    localparam int MODE_W = 3;
    // Instruction codes; an address is the slot pattern with the top bits clear
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
    localparam logic [IR_W-1:0] INS_GO_TO_WAIT = 8'hC3;
    localparam logic [IR_W-1:0] INS_MODE_SEL = 8'h82;
    localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;
    localparam logic [IR_W-SLOT_W-1:0] ADDR_PREFIX = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
    // Master side: mclk cycles per half period of the generated test clock
    localparam int TCK_HALF_CYC = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 2;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
    } mdjb_tap_e;

    typedef enum logic [1:0] {
        HST_IDLE = 2'h0, HST_LOW = 2'h1, HST_HIGH = 2'h2
    } mdjb_hst_e;
endpackage

// >>> src/mdjb_if.sv
// Four-wire backplane test bus plus reset between master and bridge
interface mdjb_if;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;

    // Bridge end
    modport dev (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
    // Scan master end
    modport mst (output tck, output tms, output tdi, output trst_n, input tdo, input tdo_oe);
endinterface

// >>> src/mdjb_dev.sv
// Bridge end: slot-addressed test access port with three local scan ports
//
// Contract
// - Unselected: watch bus, honour only own address and go-to-wait
// - Unselected: no data register or port reachable
// - Correct address selects; then instructions accepted
// - All parked: chain is bridge register only
// - Unparked: bridge register, ring, pad, output
// - One pad bit after each ring
// - Pad captures ring data on falling edge
// - Single selected bridge speaks standard scan protocol
// - Mode select steps bridge and local controllers
// - Serial data enters only on data input
// - Data output returns bridge and ring data
// - Backplane test clock is the only clock
// - Test reset low initialises asynchronously
// - Address comes from six slot inputs
// - Enable high floats all local port outputs
// - Bit 0 is rightmost, least significant
// - Local test clock buffers backplane clock
// - Parked port holds mode select constant
// - Instruction equal to slot pattern selects
module mdjb_dev #(
    parameter int NPORT = mdjb_pkg::NPORT
) (
    mdjb_if.dev link,
    input wire logic [mdjb_pkg::SLOT_W-1:0] slot_id,
    input wire logic lp_oe_n,
    input wire logic [NPORT-1:0] lp_tdi,
    output logic [NPORT-1:0] lp_tck,
    output logic [NPORT-1:0] lp_tms,
    output logic [NPORT-1:0] lp_tdo,
    output logic [NPORT-1:0] lp_oe
);
    mdjb_pkg::mdjb_tap_e tap_r;
    mdjb_pkg::mdjb_tap_e tap_nxt;
    logic [mdjb_pkg::IR_W-1:0] ir_sh_r;
    logic [mdjb_pkg::IR_W-1:0] ir_r;
    logic [NPORT-1:0] mode_r;
    logic [NPORT-1:0] mode_sh_r;
    logic byp_r;
    logic sel_r;
    logic [mdjb_pkg::SLOT_W-1:0] slot_s1_r;
    logic [mdjb_pkg::SLOT_W-1:0] slot_s2_r;
    logic oe_s1_r;
    logic oe_s2_r;
    logic br_tdo_r;
    logic [NPORT-1:0] pad_r;
    logic tdo_oe_r;
    logic bridge_out;
    logic addr_hit;
    logic mode_dr;
    logic chain_out;
    logic [NPORT-1:0] seg_in;

    // Standard 16-state controller transition
    function automatic mdjb_pkg::mdjb_tap_e tap_step(input mdjb_pkg::mdjb_tap_e s,
                                                     input logic tms);
        mdjb_pkg::mdjb_tap_e n;
        n = s;
        unique case (s)
            mdjb_pkg::TAP_RESET: n = tms ? mdjb_pkg::TAP_RESET : mdjb_pkg::TAP_IDLE;
            mdjb_pkg::TAP_IDLE: n = tms ? mdjb_pkg::TAP_SEL_DR : mdjb_pkg::TAP_IDLE;
            mdjb_pkg::TAP_SEL_DR: n = tms ? mdjb_pkg::TAP_SEL_IR : mdjb_pkg::TAP_CAP_DR;
            mdjb_pkg::TAP_CAP_DR: n = tms ? mdjb_pkg::TAP_EX1_DR : mdjb_pkg::TAP_SH_DR;
            mdjb_pkg::TAP_SH_DR: n = tms ? mdjb_pkg::TAP_EX1_DR : mdjb_pkg::TAP_SH_DR;
            mdjb_pkg::TAP_EX1_DR: n = tms ? mdjb_pkg::TAP_UPD_DR : mdjb_pkg::TAP_PA_DR;
            mdjb_pkg::TAP_PA_DR: n = tms ? mdjb_pkg::TAP_EX2_DR : mdjb_pkg::TAP_PA_DR;
            mdjb_pkg::TAP_EX2_DR: n = tms ? mdjb_pkg::TAP_UPD_DR : mdjb_pkg::TAP_SH_DR;
            mdjb_pkg::TAP_UPD_DR: n = tms ? mdjb_pkg::TAP_SEL_DR : mdjb_pkg::TAP_IDLE;
            mdjb_pkg::TAP_SEL_IR: n = tms ? mdjb_pkg::TAP_RESET : mdjb_pkg::TAP_CAP_IR;
            mdjb_pkg::TAP_CAP_IR: n = tms ? mdjb_pkg::TAP_EX1_IR : mdjb_pkg::TAP_SH_IR;
            mdjb_pkg::TAP_SH_IR: n = tms ? mdjb_pkg::TAP_EX1_IR : mdjb_pkg::TAP_SH_IR;
            mdjb_pkg::TAP_EX1_IR: n = tms ? mdjb_pkg::TAP_UPD_IR : mdjb_pkg::TAP_PA_IR;
            mdjb_pkg::TAP_PA_IR: n = tms ? mdjb_pkg::TAP_EX2_IR : mdjb_pkg::TAP_PA_IR;
            mdjb_pkg::TAP_EX2_IR: n = tms ? mdjb_pkg::TAP_UPD_IR : mdjb_pkg::TAP_SH_IR;
            mdjb_pkg::TAP_UPD_IR: n = tms ? mdjb_pkg::TAP_SEL_DR : mdjb_pkg::TAP_IDLE;
        endcase
        return n;
    endfunction

    assign tap_nxt = tap_step(tap_r, link.tms);

    // Controller state, stepped by mode select on the backplane clock
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            tap_r <= mdjb_pkg::TAP_RESET;
        end else begin
            tap_r <= tap_nxt;
        end
    end

    // Static pins: two stages before the compare reads them
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            slot_s1_r <= '0;
            slot_s2_r <= '0;
            oe_s1_r <= 1'b1;
            oe_s2_r <= 1'b1;
        end else begin
            slot_s1_r <= slot_id;
            slot_s2_r <= slot_s1_r;
            oe_s1_r <= lp_oe_n;
            oe_s2_r <= oe_s1_r;
        end
    end

    // Address match against the slot pattern
    assign addr_hit = (ir_sh_r == {mdjb_pkg::ADDR_PREFIX, slot_s2_r});
    assign mode_dr = (ir_r == mdjb_pkg::INS_MODE_SEL);

    // Instruction shifter: shifts toward bit 0 so the rightmost bit leaves first
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            ir_sh_r <= mdjb_pkg::IR_CAPTURE;
        end else if (tap_r == mdjb_pkg::TAP_CAP_IR) begin
            ir_sh_r <= mdjb_pkg::IR_CAPTURE;
        end else if (tap_r == mdjb_pkg::TAP_SH_IR) begin
            ir_sh_r <= {link.tdi, ir_sh_r[mdjb_pkg::IR_W-1:1]};
        end
    end

    // Selection and current instruction; the shifter keeps watching while unselected
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            sel_r <= 1'b0;
            ir_r <= mdjb_pkg::INS_BYPASS;
        end else if (tap_r == mdjb_pkg::TAP_RESET) begin
            ir_r <= mdjb_pkg::INS_BYPASS;
        end else if (tap_r == mdjb_pkg::TAP_UPD_IR) begin
            if (ir_sh_r == mdjb_pkg::INS_GO_TO_WAIT) begin
                sel_r <= 1'b0;
                ir_r <= mdjb_pkg::INS_BYPASS;
            end else if (!sel_r) begin
                // Anything but an address match is ignored here
                if (addr_hit) begin
                    sel_r <= 1'b1;
                end
            end else begin
                ir_r <= ir_sh_r;
            end
        end
    end

    // Mode register: one unpark bit per local port, bit 0 is port 1
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            mode_r <= NPORT'(mdjb_pkg::MODE_RESET);
            mode_sh_r <= NPORT'(mdjb_pkg::MODE_RESET);
        end else if (tap_r == mdjb_pkg::TAP_UPD_IR && ir_sh_r == mdjb_pkg::INS_GO_TO_WAIT) begin
            mode_r <= NPORT'(mdjb_pkg::MODE_RESET); // Waiting bridge parks every port
        end else if (sel_r && mode_dr) begin
            unique case (tap_r)
                mdjb_pkg::TAP_CAP_DR: mode_sh_r <= mode_r;
                mdjb_pkg::TAP_SH_DR: mode_sh_r <= {link.tdi, mode_sh_r[NPORT-1:1]};
                mdjb_pkg::TAP_UPD_DR: mode_r <= mode_sh_r;
                default: mode_sh_r <= mode_sh_r;
            endcase
        end
    end

    // Bypass bit for every other instruction
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            byp_r <= 1'b0;
        end else if (tap_r == mdjb_pkg::TAP_CAP_DR) begin
            byp_r <= 1'b0;
        end else if (tap_r == mdjb_pkg::TAP_SH_DR) begin
            byp_r <= link.tdi;
        end
    end

    // Bit presented by the bridge's current register
    always_comb begin
        if (tap_r == mdjb_pkg::TAP_SH_IR) begin
            bridge_out = ir_sh_r[0];
        end else if (mode_dr) begin
            bridge_out = mode_sh_r[0];
        end else begin
            bridge_out = byp_r;
        end
    end

    // Falling-edge retiming of the bridge bit and of each returning ring
    always_ff @(negedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            br_tdo_r <= 1'b0;
            pad_r <= '0;
            tdo_oe_r <= 1'b0;
        end else begin
            br_tdo_r <= bridge_out;
            pad_r <= lp_tdi;
            tdo_oe_r <= sel_r && (tap_r == mdjb_pkg::TAP_SH_DR
                                  || tap_r == mdjb_pkg::TAP_SH_IR);
        end
    end

    // Chain walk: each unparked ring is fed by the stage before and ends in its pad
    always_comb begin
        logic cur;
        cur = br_tdo_r;
        seg_in = '0;
        for (int i = 0; i < NPORT; i++) begin
            seg_in[i] = cur;
            if (mode_r[i]) begin
                cur = pad_r[i];
            end
        end
        chain_out = cur;
    end

    // Output is only driven while a selected bridge shifts
    assign link.tdo = chain_out;
    assign link.tdo_oe = tdo_oe_r;

    // Local ports: clock buffered, mode select frozen low while parked
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            lp_tck[i] = link.tck;
            lp_tms[i] = mode_r[i] ? link.tms : 1'b0;
            lp_tdo[i] = seg_in[i];
            lp_oe[i] = !oe_s2_r;
        end
    end
endmodule

// >>> src/mdjb_host.sv
// Backplane scan master end with its command FIFO
module mdjb_fifo #(
    parameter int W = mdjb_pkg::FIFO_W,
    parameter int D = mdjb_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW + 1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage has no reset; only the pointers matter
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

module mdjb_host (
    input wire logic mclk,
    input wire logic arst_n,
    mdjb_if.mst link,
    input wire logic link_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_tms,
    input wire logic cmd_tdi,
    output logic rsp_valid,
    output logic rsp_tdo,
    output logic rsp_drv
);
    mdjb_pkg::mdjb_hst_e st_r;
    logic [mdjb_pkg::FIFO_W-1:0] q_data;
    logic q_valid;
    logic q_pop;
    logic [7:0] cnt_r;
    logic tck_r;
    logic tms_r;
    logic tdi_r;
    logic trst_n_r;
    logic tdo_s1_r;
    logic tdo_s2_r;
    logic oe_s1_r;
    logic oe_s2_r;
    logic cnt_done;

    // Back-pressure: cmd_ready drops when eight bits wait
    mdjb_fifo #(.W(mdjb_pkg::FIFO_W), .D(mdjb_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_tms, cmd_tdi}),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .out_data(q_data)
    );

    assign cnt_done = (cnt_r == '0);
    assign q_pop = q_valid && (st_r == mdjb_pkg::HST_IDLE
                               || (st_r == mdjb_pkg::HST_HIGH && cnt_done));

    // Returning data crosses from the link clock through two stages
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tdo_s1_r <= 1'b0;
            tdo_s2_r <= 1'b0;
            oe_s1_r <= 1'b0;
            oe_s2_r <= 1'b0;
        end else begin
            tdo_s1_r <= link.tdo;
            tdo_s2_r <= tdo_s1_r;
            oe_s1_r <= link.tdo_oe;
            oe_s2_r <= oe_s1_r;
        end
    end

    // Bit sequencer: divider makes the test clock, one FIFO entry per period
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= mdjb_pkg::HST_IDLE;
            cnt_r <= '0;
            tck_r <= 1'b0;
            tms_r <= 1'b1;
            tdi_r <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_tdo <= 1'b0;
            rsp_drv <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (q_pop) begin
                // Mode select and data change only while the clock is low
                tms_r <= q_data[1];
                tdi_r <= q_data[0];
                tck_r <= 1'b0;
                cnt_r <= 8'(mdjb_pkg::TCK_HALF_CYC - 1);
                st_r <= mdjb_pkg::HST_LOW;
            end else begin
                unique case (st_r)
                    mdjb_pkg::HST_IDLE: st_r <= mdjb_pkg::HST_IDLE;
                    mdjb_pkg::HST_LOW: begin
                        if (cnt_done) begin
                            // Sample just before the rising edge, settled since the fall
                            tck_r <= 1'b1;
                            rsp_valid <= 1'b1;
                            rsp_tdo <= tdo_s2_r;
                            rsp_drv <= oe_s2_r;
                            cnt_r <= 8'(mdjb_pkg::TCK_HALF_CYC - 1);
                            st_r <= mdjb_pkg::HST_HIGH;
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                    mdjb_pkg::HST_HIGH: begin
                        if (cnt_done) begin
                            tck_r <= 1'b0; // Clock parks low when the queue is empty
                            st_r <= mdjb_pkg::HST_IDLE;
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                    default: st_r <= mdjb_pkg::HST_IDLE;
                endcase
            end
        end
    end

    // Test reset follows the request level, held low while this end resets
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trst_n_r <= 1'b0;
        end else begin
            trst_n_r <= !link_rst;
        end
    end

    assign link.tck = tck_r;
    assign link.tms = tms_r;
    assign link.tdi = tdi_r;
    assign link.trst_n = trst_n_r;
endmodule

// >>> tb/mdjb_checker.sv
// Concurrent checks on the backplane scan bus between scan master and bridge
module mdjb_checker (
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Next-state tables of the 16-state controller, one nibble per state
    localparam logic [63:0] NX0 = 64'h1BDDBBA1_46644311;
    localparam logic [63:0] NX1 = 64'h2FEFCC02_87855920;
    logic [3:0] st_r;
    logic tms_pos_r;
    logic tdi_pos_r;
    logic [mdjb_pkg::IR_W-1:0] irs_r;
    logic [mdjb_pkg::IR_W-1:0] ins_r;
    logic [mdjb_pkg::MODE_W-1:0] msh_r;
    logic [mdjb_pkg::MODE_W-1:0] unpark_r;
    logic drv_r;

    // Reference controller, stepped on the same rising edges as the bridge
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st_r <= mdjb_pkg::TAP_RESET;
        end else begin
            st_r <= tms ? NX1[st_r * 4 +: 4] : NX0[st_r * 4 +: 4];
        end
    end

    // Values seen at the rising edge, so the falling edge can spot a late change
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tms_pos_r <= 1'b1;
            tdi_pos_r <= 1'b1;
        end else begin
            tms_pos_r <= tms;
            tdi_pos_r <= tdi;
        end
    end

    // Shadow of instruction and mode registers rebuilt from the bus alone;
    // a bridge that drove tdo_oe in the shift just ended is a selected one
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            irs_r <= mdjb_pkg::IR_CAPTURE;
            ins_r <= mdjb_pkg::INS_BYPASS;
            msh_r <= mdjb_pkg::MODE_RESET;
            unpark_r <= mdjb_pkg::MODE_RESET;
            drv_r <= 1'b0;
        end else begin
            if (st_r == mdjb_pkg::TAP_SH_IR || st_r == mdjb_pkg::TAP_SH_DR) begin
                drv_r <= tdo_oe;
            end
            if (st_r == mdjb_pkg::TAP_CAP_IR) begin
                irs_r <= mdjb_pkg::IR_CAPTURE;
            end else if (st_r == mdjb_pkg::TAP_SH_IR) begin
                irs_r <= {tdi, irs_r[mdjb_pkg::IR_W-1:1]};
            end
            if (st_r == mdjb_pkg::TAP_CAP_DR) begin
                msh_r <= unpark_r;
            end else if (st_r == mdjb_pkg::TAP_SH_DR) begin
                msh_r <= {tdi, msh_r[mdjb_pkg::MODE_W-1:1]};
            end
            if (st_r == mdjb_pkg::TAP_RESET) begin
                ins_r <= mdjb_pkg::INS_BYPASS;
            end else if (st_r == mdjb_pkg::TAP_UPD_IR && irs_r == mdjb_pkg::INS_GO_TO_WAIT) begin
                ins_r <= mdjb_pkg::INS_BYPASS;
                unpark_r <= mdjb_pkg::MODE_RESET;
            end else if (st_r == mdjb_pkg::TAP_UPD_IR && drv_r) begin
                ins_r <= irs_r;
            end else if (st_r == mdjb_pkg::TAP_UPD_DR && drv_r
                         && ins_r == mdjb_pkg::INS_MODE_SEL) begin
                unpark_r <= msh_r;
            end
        end
    end

    // Capture bits lead only with every ring parked; an open ring's data comes first
    sequence s_ir_first;
        st_r == mdjb_pkg::TAP_SH_IR && $past(st_r) == mdjb_pkg::TAP_CAP_IR && tdo_oe
            && unpark_r == mdjb_pkg::MODE_RESET;
    endsequence
    sequence s_shift_run;
        st_r == mdjb_pkg::TAP_SH_DR && $past(st_r) == mdjb_pkg::TAP_SH_DR;
    endsequence

    // Output driven only while a shift state is under way
    property p_oe_in_shift;
        @(posedge tck) disable iff (!trst_n)
        tdo_oe |-> (st_r == mdjb_pkg::TAP_SH_DR || st_r == mdjb_pkg::TAP_SH_IR);
    endproperty
    a_oe_in_shift: assert property (p_oe_in_shift)
        else $error("tdo_oe high outside shift");

    property p_tlr_quiet;
        @(posedge tck) disable iff (!trst_n)
        st_r == mdjb_pkg::TAP_RESET |-> !tdo_oe;
    endproperty
    a_tlr_quiet: assert property (p_tlr_quiet)
        else $error("tdo_oe high in reset state");

    // Five mode-select ones must land in reset whatever the start state
    property p_five_tms;
        @(posedge tck) disable iff (!trst_n)
        tms [*5] |=> !tdo_oe;
    endproperty
    a_five_tms: assert property (p_five_tms)
        else $error("tdo_oe high after five ones");

    property p_ir_capture;
        @(posedge tck) disable iff (!trst_n)
        s_ir_first |-> tdo == mdjb_pkg::IR_CAPTURE[0]
            ##1 (st_r != mdjb_pkg::TAP_SH_IR || tdo == mdjb_pkg::IR_CAPTURE[1]);
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("bad capture bits");

    // Selection cannot change in mid-shift, so the drive must hold
    property p_oe_steady;
        @(posedge tck) disable iff (!trst_n)
        s_shift_run |-> $stable(tdo_oe);
    endproperty
    a_oe_steady: assert property (p_oe_steady)
        else $error("tdo_oe toggled in shift");

    property p_idle_quiet;
        @(posedge tck) disable iff (!trst_n)
        st_r == mdjb_pkg::TAP_IDLE |-> !tdo_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("tdo_oe high in idle");

    property p_tms_hold;
        @(negedge tck) disable iff (!trst_n)
        tms == tms_pos_r;
    endproperty
    a_tms_hold: assert property (p_tms_hold)
        else $error("tms moved with tck high");

    property p_tdi_hold;
        @(negedge tck) disable iff (!trst_n)
        tdi == tdi_pos_r;
    endproperty
    a_tdi_hold: assert property (p_tdi_hold)
        else $error("tdi moved with tck high");
endmodule

// >>> tb/tb_top.sv
// Self-checking bench: scan master and bridge joined on the backplane bus
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CEIL = 40000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic link_rst = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_tms = 1'b1;
    logic cmd_tdi = 1'b1;
    logic lp_oe_n = 1'b1;
    logic [mdjb_pkg::SLOT_W-1:0] slot_id = 6'h00;
    logic cmd_ready, rsp_valid, rsp_tdo, rsp_drv;
    logic [2:0] lp_tdi, lp_tck, lp_tms, lp_tdo, lp_oe;
    logic [7:0] ring_r [3] = '{8'h00, 8'h00, 8'h00};
    logic [2:0] rout_r = 3'h0;
    logic [2:0] exp_mask = 3'h0;
    logic [31:0] lfsr = 32'h895B;
    logic saw_full = 1'b0;
    logic tq[$];
    logic dq[$];
    logic [1:0] rq[$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    mdjb_if link();
    mdjb_host u_mdjb_host (.mclk(mclk), .arst_n(arst_n), .link(link), .link_rst(link_rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_tms(cmd_tms), .cmd_tdi(cmd_tdi),
        .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo), .rsp_drv(rsp_drv));
    mdjb_dev u_mdjb_dev (.link(link), .slot_id(slot_id), .lp_oe_n(lp_oe_n), .lp_tdi(lp_tdi),
        .lp_tck(lp_tck), .lp_tms(lp_tms), .lp_tdo(lp_tdo), .lp_oe(lp_oe));
    mdjb_checker u_mdjb_checker (.tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .trst_n(link.trst_n), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // Local rings of 2, 3 and 4 bits; a floated input sees a changing level
    for (genvar gi = 0; gi < 3; gi++) begin : g_ring
        always @(posedge lp_tck[gi]) begin
            ring_r[gi] <= {ring_r[gi][6:0], lp_oe[gi] ? lp_tdo[gi] : ~ring_r[gi][0]};
        end
        // Ring devices present their last bit after the falling clock edge, as a real TAP does
        always @(negedge lp_tck[gi]) begin
            rout_r[gi] <= ring_r[gi][gi + 1];
        end
        assign lp_tdi[gi] = rout_r[gi];
    end

    // Collect one response per completed test clock rising edge
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1) rq.push_back({rsp_drv, rsp_tdo});
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            n_fail++;
            complete_run();
        end
    end

    // Local clocks follow the backplane; parked ports keep mode select low
    always @(negedge mclk) begin
        if (arst_n === 1'b1) begin
            chk("lp_tck", 8'({3{link.tck}}), 8'(lp_tck));
            chk("lp_tms_parked", 8'h00, 8'(lp_tms & ~exp_mask));
        end
    end

    function automatic logic rbit();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[0];
    endfunction

    // Chain length: bridge bit plus ring and pad of every unparked port
    function automatic int clen(input logic [2:0] m);
        int s;
        s = 1;
        for (int i = 0; i < 3; i++) if (m[i]) s += i + 3;
        return s;
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (e !== s) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic add(input logic t, input logic d);
        tq.push_back(t);
        dq.push_back(d);
    endtask

    // Push the whole stream; the FIFO refuses when full, which we note
    task automatic run();
        int w;
        w = 0;
        rq = {};
        foreach (tq[i]) begin
            cmd_valid <= 1'b1;
            cmd_tms <= tq[i];
            cmd_tdi <= dq[i];
            @(posedge mclk);
            while (cmd_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(posedge mclk);
            end
        end
        cmd_valid <= 1'b0;
        while (rq.size() < tq.size() && w < 4000) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 4000) chk("response_count", 8'h01, 8'h00);
    endtask

    task automatic tlr();
        tq = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        dq = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        run();
    endtask

    // Instruction shift from idle, LSB first, back to idle
    task automatic ir(input logic [7:0] code);
        tq = {1'b1, 1'b1, 1'b0, 1'b0};
        dq = {1'b1, 1'b1, 1'b1, 1'b1};
        for (int j = 0; j < 8; j++) add(j == 7, code[j]);
        add(1'b1, 1'b1);
        add(1'b0, 1'b1);
        run();
    endtask

    task automatic dr(input int n, input logic [2:0] v);
        tq = {1'b1, 1'b0, 1'b0};
        dq = {1'b1, 1'b1, 1'b1};
        for (int j = 0; j < n; j++) add(j == n - 1, j < 3 ? v[j] : rbit());
        add(1'b1, 1'b1);
        add(1'b0, 1'b1);
        run();
    endtask

    // Random data shift; a selected bridge returns it delayed by the chain length
    task automatic chain(input int len, input logic sel);
        dr(len + 16, {rbit(), rbit(), rbit()});
        for (int k = 0; k < len + 16; k++) begin
            chk("tdo_oe", 8'(sel), 8'(rq[3 + k][1]));
            if (sel && k >= len) chk("tdo", 8'(dq[3 + k - len]), 8'(rq[3 + k][0]));
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] addr;
        repeat (10) @(posedge mclk);
        addr = {mdjb_pkg::ADDR_PREFIX, rbit(), rbit(), rbit(), rbit(), rbit(), rbit()};
        arst_n <= 1'b1;
        lp_oe_n <= 1'b0;
        slot_id <= addr[5:0];
        @(posedge mclk);
        tlr();
        ir(addr ^ 8'h01);
        ir(mdjb_pkg::INS_MODE_SEL);
        dr(3, 3'h7);
        chain(1, 1'b0);
        $display("test unselected done");
        ir(addr);
        ir(mdjb_pkg::INS_BYPASS);
        for (int j = 0; j < 8; j++) begin
            chk("ir_capture", 8'(mdjb_pkg::IR_CAPTURE[j]), 8'(rq[4 + j][0]));
        end
        chain(1, 1'b1);
        $display("test select done");
        for (int m = 1; m < 8; m++) begin
            exp_mask = exp_mask | 3'(m);
            ir(mdjb_pkg::INS_MODE_SEL);
            dr(3, 3'(m));
            exp_mask = 3'(m);
            ir(mdjb_pkg::INS_BYPASS);
            chain(clen(3'(m)), 1'b1);
            chk("lp_oe", 8'h07, 8'(lp_oe));
        end
        $display("test ports done");
        ir(mdjb_pkg::INS_GO_TO_WAIT);
        exp_mask = 3'h0;
        chain(1, 1'b0);
        ir(addr);
        exp_mask = 3'h5;
        ir(mdjb_pkg::INS_MODE_SEL);
        dr(3, 3'h5);
        link_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        link_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        exp_mask = 3'h0;
        tlr();
        chain(1, 1'b0);
        $display("test reset done");
        lp_oe_n <= 1'b1;
        tlr();
        chk("lp_oe", 8'h00, 8'(lp_oe));
        chk("fifo_full", 8'h01, 8'(saw_full));
        $display("test float done");
        complete_run();
    end
endmodule
